/* sas_comp_model.sv */
// Analog input pins and comparator facing the converter sequencer.
// Assumes the trial code and channel come straight from the sequencer.
module sas_comp_model (
    input wire logic sys_clk_i,
    input wire logic ladder_on_i,
    input wire logic slow_i,
    input wire logic [5:0][9:0] level_i,
    input wire logic [3:0] channel_i,
    input wire logic [9:0] dac_code_i,
    output logic comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] lvl; // Level on the chosen pin
    logic hit; // Settled comparison
    logic hit_reg = 1'b0; // Late answer for slow mode
    logic junk_reg = 1'b0; // Noise while the ladder is off

    ////////////////////////////////////////////////////////////////
    // Reserved channels float low
    assign lvl = (channel_i < 4'h6) ? level_i[channel_i[2:0]] : 10'h000;
    assign hit = (lvl >= dac_code_i);

    // Slow mode settles half a clock late; a full clock would miss the trial
    always @(negedge sys_clk_i) begin
        hit_reg <= hit;
    end

    // Noise toggles every clock
    always @(posedge sys_clk_i) begin
        junk_reg <= ~junk_reg;
    end

    // No ladder means no reference, so the answer is worthless
    assign comp_o = !ladder_on_i ? junk_reg : (slow_i ? hit_reg : hit);
endmodule // sas_comp_model

/* sas_conv_timer.sv */
// Down-counter that times one conversion in oscillator clocks.
// Assumes load and stop never come in the same cycle with meaning.
module sas_conv_timer (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [sas_pkg::CNT_W-1:0] len_i,
    input wire logic stop_i,
    output logic running_o,
    output logic expire_o
);

    // Run flag and remaining count
    typedef struct packed {
        logic run;
        logic [sas_pkg::CNT_W-1:0] cnt;
    } sas_tmr_t;

    sas_tmr_t t_reg;
    sas_tmr_t t_next;

    // Load wins, so a repeat restart reloads on expiry
    always_comb begin
        t_next = t_reg;
        if (load_i) begin
            t_next.run = 1'b1;
            t_next.cnt = sas_pkg::CNT_W'(len_i - 1'b1);
        end else if (stop_i) begin
            t_next.run = 1'b0;
        end else if (t_reg.run) begin
            if (t_reg.cnt == '0) begin
                t_next.run = 1'b0;
            end else begin
                t_next.cnt = sas_pkg::CNT_W'(t_reg.cnt - 1'b1);
            end
        end
    end

    // Synchronous reset to stopped
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign running_o = t_reg.run;
    assign expire_o = t_reg.run && (t_reg.cnt == '0);

endmodule // sas_conv_timer

/* sas_pkg.sv */
// Shared constants and types of the converter sequencer.
// Assumes a 100 MHz oscillator clock and APB word access.
package sas_pkg;

    ////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] IDX_CTRL1 = 8'h0e; // Start, mode, channel
    localparam logic [7:0] IDX_CTRL2 = 8'h0f; // Time select, ladder
    localparam logic [7:0] IDX_RES_LO = 8'h20; // Low bits and flags
    localparam logic [7:0] IDX_RES_HI = 8'h21; // Upper eight bits
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = {IDX_CTRL1[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CTRL2 = {IDX_CTRL2[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RES_LO = {IDX_RES_LO[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RES_HI = {IDX_RES_HI[5:0], 2'b00};

    ////////////////////////////////////////////////////////////////
    // Operating modes and register layouts
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_RSVD = 2'h2,
        MODE_REPEAT = 2'h3
    } sas_mode_t;

    typedef struct packed {
        logic conv_start_bit; // Bit 7, clears itself
        sas_mode_t conv_op_mode; // Bits 6..5
        logic analog_in_disable; // Bit 4
        logic [3:0] channel_sel; // Bits 3..0
    } sas_ctrl1_t;

    typedef struct packed {
        logic [1:0] undef_hi; // Bits 7..6, never stored
        logic ladder_always_on; // Bit 5
        logic fixed_one; // Bit 4, software keeps it 1
        logic [2:0] conv_time_sel; // Bits 3..1
        logic fixed_zero; // Bit 0, software keeps it 0
    } sas_ctrl2_t;

    localparam sas_ctrl1_t CTRL1_RESET = 8'h10;
    localparam sas_ctrl2_t CTRL2_RESET = 8'h00;

    // Sequencer states
    typedef enum logic {ST_IDLE, ST_CONV} sas_state_t;

    ////////////////////////////////////////////////////////////////
    // Conversion time codes and lengths in oscillator clocks
    localparam int unsigned CNT_W = 11;
    localparam logic [2:0] TSEL_39 = 3'h0;
    localparam logic [2:0] TSEL_78 = 3'h2;
    localparam logic [2:0] TSEL_156 = 3'h3;
    localparam logic [2:0] TSEL_312 = 3'h4;
    localparam logic [2:0] TSEL_624 = 3'h5;
    localparam logic [2:0] TSEL_1248 = 3'h6;
    localparam logic [CNT_W-1:0] LEN_39 = 11'h027;
    localparam logic [CNT_W-1:0] LEN_78 = 11'h04e;
    localparam logic [CNT_W-1:0] LEN_156 = 11'h09c;
    localparam logic [CNT_W-1:0] LEN_312 = 11'h138;
    localparam logic [CNT_W-1:0] LEN_624 = 11'h270;
    localparam logic [CNT_W-1:0] LEN_1248 = 11'h4e0;

    // Approximation: ten trials, one every three clocks
    localparam int unsigned RES_W = 10;
    localparam logic [RES_W-1:0] RES_MSB = 10'h200;
    localparam logic [1:0] TRIAL_LAST = 2'h2;

endpackage : sas_pkg

/* sas_sync2.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the level stays for several clocks to be seen.
module sas_sync2 (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic async_i,
    output logic sync_o
);

    // Both stages in one state word
    typedef struct packed {
        logic meta; // First stage, read by second only
        logic sync; // Second stage
    } sas_sync_t;

    sas_sync_t s_reg;
    sas_sync_t s_next;

    // Shift the level along
    always_comb begin
        s_next.meta = async_i;
        s_next.sync = s_reg.meta;
    end

    // Synchronous reset to low
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_o = s_reg.sync;

endmodule // sas_sync2

/* sas_top.sv */
// Sequencer and result registers of a 10-bit approximating converter.
// Assumes an APB master, a comparator output on comp_i and a
// standby level from the clock controller on this clock.
module sas_top (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [sas_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic standby_i,
    input wire logic comp_i,
    output logic ladder_on_o,
    output logic [sas_pkg::RES_W-1:0] dac_code_o,
    output logic [3:0] channel_sel_o,
    output logic analog_in_disable_o,
    output logic conv_done_irq_o
);

    ////////////////////////////////////////////////////////////////
    // State of the whole block
    typedef struct packed {
        sas_pkg::sas_state_t state; // Idle or converting
        sas_pkg::sas_ctrl1_t c1; // First control register
        sas_pkg::sas_ctrl2_t c2; // Second control register
        logic done; // Conversion done flag
        logic irq; // Completion pulse
        logic [sas_pkg::RES_W-1:0] result; // Last full result
        logic [sas_pkg::RES_W-1:0] code; // Trial code to ladder
        logic [sas_pkg::RES_W-1:0] probe; // Bit under trial
        logic [1:0] phase; // Clocks since last trial
        logic [7:0] rdata; // Read data caught at setup
    } sas_core_t;

    sas_core_t r_reg;
    sas_core_t r_next;

    logic comp_s; // Comparator after synchroniser
    logic tmr_run; // Timer busy
    logic tmr_exp; // Last cycle of a conversion
    logic tmr_load; // Start or restart the timer
    logic go; // Software start taken
    logic abort; // Conversion halted early
    logic restart; // Repeat chaining
    logic setup; // APB setup phase
    logic access; // APB access phase
    logic hit; // Address is mapped
    logic [sas_pkg::CNT_W-1:0] len; // Length of next conversion

    ////////////////////////////////////////////////////////////////
    // Length lookup; reserved codes take the longest, safe choice
    function automatic logic [sas_pkg::CNT_W-1:0] conv_len(input logic [2:0] sel);
        case (sel)
            sas_pkg::TSEL_39: conv_len = sas_pkg::LEN_39;
            sas_pkg::TSEL_78: conv_len = sas_pkg::LEN_78;
            sas_pkg::TSEL_156: conv_len = sas_pkg::LEN_156;
            sas_pkg::TSEL_312: conv_len = sas_pkg::LEN_312;
            sas_pkg::TSEL_624: conv_len = sas_pkg::LEN_624;
            default: conv_len = sas_pkg::LEN_1248;
        endcase
    endfunction

    // Only single and repeat modes may convert
    function automatic logic mode_runs(input sas_pkg::sas_mode_t m);
        mode_runs = (m == sas_pkg::MODE_SINGLE) || (m == sas_pkg::MODE_REPEAT);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Comparator crosses in from the analog side
    sas_sync2 u_comp_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i(comp_i),
        .sync_o(comp_s)
    );

    // Conversion timer
    sas_conv_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .load_i(tmr_load),
        .len_i(len),
        .stop_i(abort),
        .running_o(tmr_run),
        .expire_o(tmr_exp)
    );

    ////////////////////////////////////////////////////////////////
    // Bus decode; zero wait states past the setup phase
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign hit = (paddr_i == sas_pkg::ADDR_CTRL1) || (paddr_i == sas_pkg::ADDR_CTRL2) ||
                 (paddr_i == sas_pkg::ADDR_RES_LO) || (paddr_i == sas_pkg::ADDR_RES_HI);
    assign pready_o = access;
    assign pslverr_o = access && !hit;
    assign len = conv_len(r_reg.c2.conv_time_sel);

    ////////////////////////////////////////////////////////////////
    // Next state of registers and sequencer
    always_comb begin
        r_next = r_reg;
        r_next.irq = 1'b0;
        go = 1'b0;
        abort = 1'b0;
        restart = 1'b0;

        // Register writes at the access phase
        if (access && pwrite_i && !standby_i) begin
            if (paddr_i == sas_pkg::ADDR_CTRL1) begin
                r_next.c1 = pwdata_i[7:0];
            end else if (paddr_i == sas_pkg::ADDR_CTRL2) begin
                r_next.c2 = {2'b00, pwdata_i[5:0]};
            end
        end

        // Reading the upper result clears done; set below wins
        if (access && !pwrite_i && paddr_i == sas_pkg::ADDR_RES_HI) begin
            r_next.done = 1'b0;
        end

        // Read data caught in setup so it comes from a flop
        if (setup) begin
            case (paddr_i)
                sas_pkg::ADDR_CTRL1: r_next.rdata = r_reg.c1;
                sas_pkg::ADDR_CTRL2: r_next.rdata = {2'b00, r_reg.c2[5:0]};
                sas_pkg::ADDR_RES_LO: r_next.rdata = {r_reg.result[1:0], r_reg.done,
                                                      r_reg.state == sas_pkg::ST_CONV, 4'h0};
                sas_pkg::ADDR_RES_HI: r_next.rdata = r_reg.result[9:2];
                default: r_next.rdata = 8'h00;
            endcase
        end

        // Sequencer
        case (r_reg.state)
            sas_pkg::ST_IDLE: begin
                // Start bit taken only in a running mode
                if (r_reg.c1.conv_start_bit && mode_runs(r_next.c1.conv_op_mode) && !standby_i) begin
                    go = 1'b1;
                end
            end
            sas_pkg::ST_CONV: begin
                if (standby_i || !mode_runs(r_next.c1.conv_op_mode)) begin
                    // Halt at once; partial code is dropped
                    abort = 1'b1;
                    r_next.state = sas_pkg::ST_IDLE;
                end else begin
                    // One trial every three clocks, MSB first
                    if (r_reg.probe != '0) begin
                        if (r_reg.phase == sas_pkg::TRIAL_LAST) begin
                            r_next.phase = 2'h0;
                            r_next.probe = r_reg.probe >> 1;
                            r_next.code = (comp_s ? r_reg.code : (r_reg.code & ~r_reg.probe)) |
                                          (r_reg.probe >> 1);
                        end else begin
                            r_next.phase = 2'(r_reg.phase + 1'b1);
                        end
                    end
                    if (tmr_exp) begin
                        r_next.result = r_reg.code;
                        r_next.done = 1'b1;
                        r_next.irq = 1'b1;
                        if (r_reg.c1.conv_op_mode == sas_pkg::MODE_REPEAT) begin
                            restart = 1'b1;
                        end else begin
                            r_next.state = sas_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                r_next.state = sas_pkg::ST_IDLE;
            end
        endcase

        // Fresh trial for a start or a chained restart
        if (go || restart) begin
            r_next.state = sas_pkg::ST_CONV;
            r_next.code = sas_pkg::RES_MSB;
            r_next.probe = sas_pkg::RES_MSB;
            r_next.phase = 2'h0;
        end
        if (go) begin
            r_next.c1.conv_start_bit = 1'b0;
            r_next.done = 1'b0;
        end

        // Standby: both controls back to reset, result lost
        if (standby_i) begin
            r_next.c1 = sas_pkg::CTRL1_RESET;
            r_next.c2 = sas_pkg::CTRL2_RESET;
            r_next.result = '0;
            r_next.done = 1'b0;
            r_next.state = sas_pkg::ST_IDLE;
        end
    end

    assign tmr_load = go || restart;

    // Synchronous reset of all state
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            r_reg <= {sas_pkg::ST_IDLE, sas_pkg::CTRL1_RESET, sas_pkg::CTRL2_RESET,
                      1'b0, 1'b0, {sas_pkg::RES_W{1'b0}}, {sas_pkg::RES_W{1'b0}},
                      {sas_pkg::RES_W{1'b0}}, 2'h0, 8'h00};
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata_o = {24'h000000, r_reg.rdata};
    assign ladder_on_o = r_reg.c2.ladder_always_on || (r_reg.state == sas_pkg::ST_CONV);
    assign dac_code_o = r_reg.code;
    assign channel_sel_o = r_reg.c1.channel_sel;
    assign analog_in_disable_o = r_reg.c1.analog_in_disable;
    assign conv_done_irq_o = r_reg.irq;

    ////////////////////////////////////////////////////////////////
    // Checks; helper counts clocks since each timer load
    logic [sas_pkg::CNT_W-1:0] a_cyc;
    logic [sas_pkg::CNT_W-1:0] a_len;
    logic busy;
    assign busy = (r_reg.state == sas_pkg::ST_CONV);

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            a_cyc <= '0;
            a_len <= '0;
        end else if (tmr_load) begin
            a_cyc <= '0;
            a_len <= len;
        end else begin
            a_cyc <= sas_pkg::CNT_W'(a_cyc + 1'b1);
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_conv_length: assert property (tmr_exp && busy |-> a_cyc == sas_pkg::CNT_W'(a_len - 1'b1))
        else $error("conversion length wrong");
    a_start_busy: assert property (go |=> busy && tmr_run)
        else $error("start did not begin conversion");
    a_start_clear: assert property (go && !(access && pwrite_i) |=> !r_reg.c1.conv_start_bit)
        else $error("start bit not cleared");
    a_new_start_done: assert property (go |=> !r_reg.done)
        else $error("done not cleared on new start");
    a_store_result: assert property (tmr_exp && !abort |=> r_reg.done && conv_done_irq_o &&
                                     r_reg.result == $past(r_reg.code))
        else $error("completion not recorded");
    a_irq_pulse: assert property (conv_done_irq_o |=> !conv_done_irq_o)
        else $error("interrupt longer than one cycle");
    a_hi_read_clr: assert property (access && !pwrite_i && paddr_i == sas_pkg::ADDR_RES_HI
                                    && !tmr_exp |=> !r_reg.done)
        else $error("upper read kept done set");
    a_abort_keep: assert property (abort && !standby_i |=> !busy && $stable(r_reg.result))
        else $error("abort changed result");
    a_repeat_chain: assert property (tmr_exp && !abort && r_reg.c1.conv_op_mode == sas_pkg::MODE_REPEAT
                                     |=> busy [*2])
        else $error("repeat did not chain");
    a_standby_init: assert property (standby_i |=> r_reg.c1 == sas_pkg::CTRL1_RESET &&
                                     r_reg.c2 == sas_pkg::CTRL2_RESET && !busy)
        else $error("standby did not reset controls");
    a_ladder_conv: assert property (busy |-> ladder_on_o)
        else $error("ladder off during conversion");
    a_irq_has_done: assert property (conv_done_irq_o |-> r_reg.done)
        else $error("interrupt without done flag");

    // Covers for the main scenarios; the long single run is timed by the helper count
    c_single: cover property (tmr_exp && busy && r_reg.c1.conv_op_mode == sas_pkg::MODE_SINGLE &&
                              a_cyc == sas_pkg::CNT_W'(sas_pkg::LEN_1248 - 1'b1));
    c_repeat: cover property (restart);
    c_abort: cover property (abort && !standby_i);
    c_standby: cover property (busy && standby_i);

endmodule // sas_top

/* sas_top_tb_top.sv */
// Self-checking bench of the converter sequencer over APB.
// Assumes the comparator model and no wait states on the bus.
module sas_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000; // Cycle ceiling for the run
    logic sys_clk = 1'b0;
    logic nrst = 1'b0; // Active low reset
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic standby = 1'b0;
    logic slow = 1'b0; // Comparator answers half a clock late
    logic [5:0][9:0] level = '0; // Pin levels as codes
    logic [31:0] prdata;
    logic pready, pslverr, ladder, aind, irq, comp;
    logic [9:0] dac;
    logic [3:0] chan;
    logic [31:0] rdata; // Last read data
    logic rerr; // Last slave error
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #5 sys_clk = ~sys_clk;

    sas_top i_dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .standby_i(standby), .comp_i(comp), .ladder_on_o(ladder), .dac_code_o(dac), .channel_sel_o(chan),
        .analog_in_disable_o(aind), .conv_done_irq_o(irq));
    sas_comp_model i_comp (.sys_clk_i(sys_clk), .ladder_on_i(ladder), .slow_i(slow), .level_i(level),
        .channel_i(chan), .dac_code_i(dac), .comp_o(comp));

    ////////////////////////////////////////////////////////////////
    // Verdict and hang guard
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            complete_run;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Bus master: setup, then access until pready at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        pen <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask

    // Cycles until the completion pulse, and how many had the ladder on
    task automatic wait_irq(output int n, output int h);
        n = 0;
        h = 0;
        do begin
            @(posedge sys_clk);
            n++;
            h += (ladder === 1'b1);
        end while (irq !== 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////
    // Expected values
    function automatic logic [31:0] conv_len(input logic [2:0] c);
        case (c)
            3'h0: return 32'h27;
            3'h2: return 32'h4e;
            3'h3: return 32'h9c;
            3'h4: return 32'h138;
            3'h5: return 32'h270;
            default: return 32'h4e0; // Reserved codes run the longest
        endcase
    endfunction

    function automatic logic [31:0] lo(input logic [9:0] v, input logic done, input logic busy);
        return {24'h0, v[1:0], done, busy, 4'h0};
    endfunction

    function automatic logic [31:0] hi(input logic [9:0] v);
        return {24'h0, v[9:2]};
    endfunction

    // One single-start conversion on a random pin and level
    task automatic one_conv(input logic [2:0] code);
        int n, h;
        logic [3:0] ch;
        logic [9:0] v;
        ch = 4'($urandom_range(5));
        v = 10'($urandom);
        level[ch] <= v;
        slow <= code[0];
        wr(sas_pkg::ADDR_CTRL2, {28'h1, code, 1'b0});
        wr(sas_pkg::ADDR_CTRL1, {24'h0, 4'ha, ch});
        wait_irq(n, h);
        check(32'(n), conv_len(code) + 32'h2);
        check(32'(h), conv_len(code));
        check({31'h0, ladder}, 32'h0);
        check({28'h0, chan}, {28'h0, ch});
        check({31'h0, aind}, 32'h0);
        check({22'h0, dac}, {22'h0, v});
        @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        rd(sas_pkg::ADDR_RES_LO, lo(v, 1'b1, 1'b0));
        rd(sas_pkg::ADDR_CTRL1, {24'h0, 4'h2, ch});
        rd(sas_pkg::ADDR_RES_HI, hi(v));
        rd(sas_pkg::ADDR_RES_LO, lo(v, 1'b0, 1'b0));
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int n, h;
        logic [9:0] v;
        void'($urandom(8));
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(sas_pkg::ADDR_CTRL1, 32'h10);
        check({31'h0, aind}, 32'h1);
        rd(sas_pkg::ADDR_CTRL2, 32'h0);
        rd(sas_pkg::ADDR_RES_HI, 32'h0);
        rd(sas_pkg::ADDR_RES_LO, 32'h0);
        rd(8'h40, 32'h0);
        check({31'h0, rerr}, 32'h1);
        wr(sas_pkg::ADDR_CTRL2, 32'hd0);
        rd(sas_pkg::ADDR_CTRL2, 32'h10);
        check({31'h0, ladder}, 32'h0);
        wr(sas_pkg::ADDR_CTRL2, 32'h30);
        @(posedge sys_clk);
        check({31'h0, ladder}, 32'h1);
        // Every time code, reserved ones included, then random levels
        for (int c = 0; c < 8; c++) one_conv(3'(c));
        repeat (4) one_conv(3'h0);
        // Restart before the result is read
        level[2] <= 10'h155;
        wr(sas_pkg::ADDR_CTRL1, 32'ha2);
        wait_irq(n, h);
        level[2] <= 10'h2aa;
        wr(sas_pkg::ADDR_CTRL1, 32'ha2);
        rd(sas_pkg::ADDR_RES_LO, lo(10'h155, 1'b0, 1'b1));
        rd(sas_pkg::ADDR_RES_HI, hi(10'h155));
        wait_irq(n, h);
        rd(sas_pkg::ADDR_RES_HI, hi(10'h2aa));
        // Repeat mode, then abort in mid-conversion
        v = 10'($urandom);
        level[4] <= v;
        wr(sas_pkg::ADDR_CTRL1, 32'he4);
        wait_irq(n, h);
        check(32'(n), 32'h29);
        wait_irq(n, h);
        check(32'(n), 32'h27);
        check(32'(h), 32'h27);
        rd(sas_pkg::ADDR_RES_LO, lo(v, 1'b1, 1'b1));
        level[4] <= ~v;
        repeat (10) @(posedge sys_clk);
        wr(sas_pkg::ADDR_CTRL1, 32'h04);
        repeat (2) @(posedge sys_clk);
        check({31'h0, ladder}, 32'h0);
        h = 0;
        repeat (60) begin
            @(posedge sys_clk);
            h += (irq === 1'b1);
        end
        check(32'(h), 32'h0);
        rd(sas_pkg::ADDR_RES_HI, hi(v));
        // Standby in mid-conversion
        wr(sas_pkg::ADDR_CTRL2, 32'h30);
        wr(sas_pkg::ADDR_CTRL1, 32'ha1);
        repeat (5) @(posedge sys_clk);
        standby <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({31'h0, ladder}, 32'h0);
        check({31'h0, aind}, 32'h1);
        rd(sas_pkg::ADDR_CTRL1, 32'h10);
        rd(sas_pkg::ADDR_CTRL2, 32'h0);
        wr(sas_pkg::ADDR_CTRL2, 32'h3c);
        wr(sas_pkg::ADDR_CTRL1, 32'h25);
        rd(sas_pkg::ADDR_CTRL2, 32'h0);
        rd(sas_pkg::ADDR_CTRL1, 32'h10);
        rd(sas_pkg::ADDR_RES_LO, 32'h0);
        standby <= 1'b0;
        h = 0;
        repeat (60) begin
            @(posedge sys_clk);
            h += (irq === 1'b1) + (ladder === 1'b1);
        end
        check(32'(h), 32'h0);
        wr(sas_pkg::ADDR_CTRL1, 32'h23);
        rd(sas_pkg::ADDR_CTRL1, 32'h23);
        complete_run;
    end
endmodule // sas_top_tb_top
